// file: logic/tcc_pkg.sv
// Package: register map, fields, modes and constants of the 16-bit timer with capture
package tcc_pkg;
  // Byte register indices on the 8-bit register port
  localparam logic [3:0] ADDR_CTRL_A = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B = 4'h1;
  localparam logic [3:0] ADDR_CNT_LO = 4'h2;
  localparam logic [3:0] ADDR_CNT_HI = 4'h3;
  localparam logic [3:0] ADDR_CAP_LO = 4'h4;
  localparam logic [3:0] ADDR_CAP_HI = 4'h5;
  localparam logic [3:0] ADDR_CMPA_LO = 4'h6;
  localparam logic [3:0] ADDR_CMPA_HI = 4'h7;
  localparam logic [3:0] ADDR_FLAGS = 4'h8;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h9;
  localparam logic [3:0] ADDR_CMP_CS = 4'hA;
  // Field positions
  localparam int CTRL_A_WGM_LSB = 0;
  localparam int CTRL_B_CS_LSB = 0;
  localparam int CTRL_B_WGM_LSB = 3;
  localparam int CTRL_B_EDGE_BIT = 6;
  localparam int CTRL_B_FILT_BIT = 7;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CAP_BIT = 5;
  localparam int CMP_CS_SEL_BIT = 2;
  localparam int CMP_CS_OUT_BIT = 5;
  // Values
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [2:0] CS_STOPPED = 3'h0;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int FILTER_SAMPLES = 4;
  // Waveform modes
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_PC8 = 4'h1;
  localparam logic [3:0] WGM_PC9 = 4'h2;
  localparam logic [3:0] WGM_PC10 = 4'h3;
  localparam logic [3:0] WGM_CTC_A = 4'h4;
  localparam logic [3:0] WGM_FAST8 = 4'h5;
  localparam logic [3:0] WGM_FAST9 = 4'h6;
  localparam logic [3:0] WGM_FAST10 = 4'h7;
  localparam logic [3:0] WGM_PFC_CAP = 4'h8;
  localparam logic [3:0] WGM_PFC_A = 4'h9;
  localparam logic [3:0] WGM_PC_CAP = 4'hA;
  localparam logic [3:0] WGM_PC_A = 4'hB;
  localparam logic [3:0] WGM_CTC_CAP = 4'hC;
  localparam logic [3:0] WGM_FAST_CAP = 4'hE;
  localparam logic [3:0] WGM_FAST_A = 4'hF;
  typedef enum logic [0:0] {DIR_UP, DIR_DOWN} tcc_dir_t;
endpackage

// file: logic/tcc_filter.sv
// Four-sample noise filter for the capture input
`timescale 1ns/1ps
`default_nettype none
module tcc_filter #(
  parameter int SAMPLES = tcc_pkg::FILTER_SAMPLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  import tcc_pkg::*;
  initial begin
    if (SAMPLES < 2) begin
      $error("tcc_filter needs at least two samples");
    end
  end
  typedef struct packed {
    logic [SAMPLES-1:0] hist;
    logic out;
  } tcc_filt_t;
  tcc_filt_t st_reg;
  tcc_filt_t st_next;
  always_comb begin
    st_next = st_reg;
    st_next.hist = {st_reg.hist[SAMPLES-2:0], din};
    // Output follows only when the newest samples all agree
    if (&st_next.hist) begin
      st_next.out = 1'b1;
    end else if (~|st_next.hist) begin
      st_next.out = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign dout = st_reg.out;
  filter_agree_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg.out != $past(st_reg.out))
      |-> ($past({st_reg.hist[SAMPLES-2:0], din}) == {SAMPLES{st_reg.out}}))
    else $error("Filter output changed without agreeing samples");
endmodule
`default_nettype wire

// file: logic/tcc_timer.sv
// Top: 16-bit timer counter with input capture and shared high-byte holding register
`timescale 1ns/1ps
`default_nettype none
module tcc_timer (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic [4:0] PRESCALE_TICK,
  input wire logic EXTERNAL_COUNT_PIN,
  input wire logic CAPTURE_INPUT_PIN,
  input wire logic COMPARATOR_OUTPUT,
  input wire logic OVF_IRQ_ACK,
  input wire logic CAP_IRQ_ACK,
  output logic OVF_IRQ,
  output logic CAP_IRQ,
  output logic [15:0] COUNT_VALUE
);
  import tcc_pkg::*;
  typedef struct packed {
    logic [7:0] timer_control_a;
    logic [7:0] timer_control_b;
    logic [7:0] hold;
    logic [15:0] count_value;
    logic [15:0] capture_value;
    logic [15:0] compare_a_value;
    logic overflow_flag;
    logic capture_flag;
    logic ovf_irq_enable;
    logic capture_irq_enable;
    logic comparator_capture_select;
    tcc_dir_t dir;
    logic [1:0] ext_sync;
    logic ext_prev;
    logic [1:0] cap_sync;
    logic edge_prev;
    logic [7:0] rdata;
    logic ovf_irq;
    logic cap_irq;
  } tcc_state_t;
  tcc_state_t st_reg;
  tcc_state_t st_next;
  logic filt_out;
  logic cap_src;
  assign cap_src = st_reg.comparator_capture_select ? COMPARATOR_OUTPUT : CAPTURE_INPUT_PIN;
  // ------------------------------
  // Noise filter
  // ------------------------------
  tcc_filter #(.SAMPLES(FILTER_SAMPLES)) u_filter (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .din(st_reg.cap_sync[1]),
    .dout(filt_out)
  );
  // ------------------------------
  // Helpers
  // ------------------------------
  function automatic logic [3:0] wgm_of(input logic [7:0] ca, input logic [7:0] cb);
    wgm_of = {cb[CTRL_B_WGM_LSB+1], cb[CTRL_B_WGM_LSB], ca[CTRL_A_WGM_LSB+1], ca[CTRL_A_WGM_LSB]};
  endfunction
  function automatic logic top_from_capture(input logic [3:0] m);
    top_from_capture = (m == WGM_PFC_CAP) || (m == WGM_PC_CAP) || (m == WGM_CTC_CAP) ||
                       (m == WGM_FAST_CAP);
  endfunction
  logic [3:0] wgm;
  logic [15:0] top;
  logic tick;
  logic is_pc;
  logic is_ctc;
  logic edge_in;
  logic capture_evt;
  assign wgm = wgm_of(st_reg.timer_control_a, st_reg.timer_control_b);
  // Top value per mode
  always_comb begin
    top = CNT_MAX;
    case (wgm)
      WGM_PC8, WGM_FAST8: top = TOP_8BIT;
      WGM_PC9, WGM_FAST9: top = TOP_9BIT;
      WGM_PC10, WGM_FAST10: top = TOP_10BIT;
      WGM_CTC_A, WGM_PFC_A, WGM_PC_A, WGM_FAST_A: top = st_reg.compare_a_value;
      WGM_PFC_CAP, WGM_PC_CAP, WGM_CTC_CAP, WGM_FAST_CAP: top = st_reg.capture_value;
      default: top = CNT_MAX;
    endcase
  end
  assign is_pc = (wgm >= WGM_PC8 && wgm <= WGM_PC10) || (wgm >= WGM_PFC_CAP && wgm <= WGM_PC_A);
  assign is_ctc = (wgm == WGM_CTC_A) || (wgm == WGM_CTC_CAP);
  // Tick selection
  always_comb begin
    tick = 1'b0;
    case (st_reg.timer_control_b[CTRL_B_CS_LSB+2:CTRL_B_CS_LSB])
      CS_STOPPED: tick = 1'b0;
      CS_EXT_FALL: tick = st_reg.ext_prev & ~st_reg.ext_sync[1];
      CS_EXT_RISE: tick = ~st_reg.ext_prev & st_reg.ext_sync[1];
      default: tick = PRESCALE_TICK[st_reg.timer_control_b[CTRL_B_CS_LSB+2:CTRL_B_CS_LSB] - 3'h1];
    endcase
  end
  // Filtered or direct input, edge polarity
  assign edge_in = st_reg.timer_control_b[CTRL_B_FILT_BIT] ? filt_out : st_reg.cap_sync[1];
  assign capture_evt = !top_from_capture(wgm) &&
    (st_reg.timer_control_b[CTRL_B_EDGE_BIT] ? (edge_in & ~st_reg.edge_prev)
                                             : (~edge_in & st_reg.edge_prev));
  // ------------------------------
  // Next state
  // ------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.ext_sync = {st_reg.ext_sync[0], EXTERNAL_COUNT_PIN};
    st_next.ext_prev = st_reg.ext_sync[1];
    // Pin or comparator source; port-driven pin behaves the same
    st_next.cap_sync = {st_reg.cap_sync[0], cap_src};
    st_next.edge_prev = edge_in;
    st_next.rdata = BYTE_ZERO;
    // Counting
    if (tick) begin
      if (is_pc) begin
        if (st_reg.dir == DIR_UP) begin
          if (st_reg.count_value >= top) begin
            st_next.dir = DIR_DOWN;
            st_next.count_value = st_reg.count_value - 16'h0001;
          end else begin
            st_next.count_value = st_reg.count_value + 16'h0001;
          end
        end else if (st_reg.count_value == CNT_BOTTOM) begin
          st_next.dir = DIR_UP;
          st_next.count_value = st_reg.count_value + 16'h0001;
          st_next.overflow_flag = 1'b1;
        end else begin
          st_next.count_value = st_reg.count_value - 16'h0001;
        end
      end else if (st_reg.count_value == top) begin
        st_next.count_value = CNT_BOTTOM;
        st_next.dir = DIR_UP;
        if (!is_ctc) begin
          st_next.overflow_flag = 1'b1;
        end
      end else begin
        st_next.count_value = st_reg.count_value + 16'h0001;
        if (st_reg.count_value == CNT_MAX) begin
          st_next.overflow_flag = 1'b1;
        end
      end
    end
    // Flag clears by acknowledge
    if (OVF_IRQ_ACK) begin
      st_next.overflow_flag = 1'b0;
    end
    if (CAP_IRQ_ACK) begin
      st_next.capture_flag = 1'b0;
    end
    // Register reads
    if (RD) begin
      if (ADDR == ADDR_CTRL_A) begin
        st_next.rdata = st_reg.timer_control_a;
      end else if (ADDR == ADDR_CTRL_B) begin
        st_next.rdata = st_reg.timer_control_b;
      end else if (ADDR == ADDR_CNT_LO) begin
        st_next.rdata = st_reg.count_value[7:0];
        st_next.hold = st_reg.count_value[15:8];
      end else if (ADDR == ADDR_CAP_LO) begin
        st_next.rdata = st_reg.capture_value[7:0];
        st_next.hold = st_reg.capture_value[15:8];
      end else if (ADDR == ADDR_CNT_HI || ADDR == ADDR_CAP_HI) begin
        st_next.rdata = st_reg.hold;
      end else if (ADDR == ADDR_CMPA_LO) begin
        st_next.rdata = st_reg.compare_a_value[7:0];
      end else if (ADDR == ADDR_CMPA_HI) begin
        st_next.rdata = st_reg.compare_a_value[15:8];
      end else if (ADDR == ADDR_FLAGS) begin
        st_next.rdata[FLAG_OVF_BIT] = st_reg.overflow_flag;
        st_next.rdata[FLAG_CAP_BIT] = st_reg.capture_flag;
      end else if (ADDR == ADDR_IRQ_EN) begin
        st_next.rdata[FLAG_OVF_BIT] = st_reg.ovf_irq_enable;
        st_next.rdata[FLAG_CAP_BIT] = st_reg.capture_irq_enable;
      end else if (ADDR == ADDR_CMP_CS) begin
        st_next.rdata[CMP_CS_SEL_BIT] = st_reg.comparator_capture_select;
        st_next.rdata[CMP_CS_OUT_BIT] = COMPARATOR_OUTPUT;
      end
    end
    // Register writes; counter write beats counting
    if (WR) begin
      if (ADDR == ADDR_CTRL_A) begin
        st_next.timer_control_a = WDATA;
      end else if (ADDR == ADDR_CTRL_B) begin
        st_next.timer_control_b = WDATA;
      end else if (ADDR == ADDR_CNT_HI || ADDR == ADDR_CAP_HI || ADDR == ADDR_CMPA_HI) begin
        st_next.hold = WDATA;
      end else if (ADDR == ADDR_CNT_LO) begin
        st_next.count_value = {st_reg.hold, WDATA};
      end else if (ADDR == ADDR_CAP_LO) begin
        if (top_from_capture(wgm)) begin
          st_next.capture_value = {st_reg.hold, WDATA};
        end
      end else if (ADDR == ADDR_CMPA_LO) begin
        st_next.compare_a_value = {st_reg.hold, WDATA};
      end else if (ADDR == ADDR_FLAGS) begin
        if (WDATA[FLAG_OVF_BIT]) begin
          st_next.overflow_flag = 1'b0;
        end
        if (WDATA[FLAG_CAP_BIT]) begin
          st_next.capture_flag = 1'b0;
        end
      end else if (ADDR == ADDR_IRQ_EN) begin
        st_next.ovf_irq_enable = WDATA[FLAG_OVF_BIT];
        st_next.capture_irq_enable = WDATA[FLAG_CAP_BIT];
      end else if (ADDR == ADDR_CMP_CS) begin
        st_next.comparator_capture_select = WDATA[CMP_CS_SEL_BIT];
      end
    end
    // Capture: set wins over clear, overwrites old value
    if (capture_evt) begin
      st_next.capture_value = st_reg.count_value;
      st_next.capture_flag = 1'b1;
    end
    st_next.ovf_irq = st_next.overflow_flag & st_next.ovf_irq_enable;
    st_next.cap_irq = st_next.capture_flag & st_next.capture_irq_enable;
  end
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign RDATA = st_reg.rdata;
  assign OVF_IRQ = st_reg.ovf_irq;
  assign CAP_IRQ = st_reg.cap_irq;
  assign COUNT_VALUE = st_reg.count_value;
  // ------------------------------
  // Checks
  // ------------------------------
  low_write_atomic_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (WR && ADDR == ADDR_CNT_LO) |=> (st_reg.count_value == {$past(st_reg.hold), $past(WDATA)}))
    else $error("Counter low write did not load both bytes");
  low_read_hold_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (RD && ADDR == ADDR_CAP_LO && !WR) |=> (st_reg.hold == $past(st_reg.capture_value[15:8])))
    else $error("Capture low read did not latch upper byte");
  stopped_count_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (st_reg.timer_control_b[2:0] == CS_STOPPED && !WR) |=> $stable(st_reg.count_value))
    else $error("Counter moved with no clock selected");
  capture_copy_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    capture_evt |=> (st_reg.capture_flag && st_reg.capture_value == $past(st_reg.count_value)))
    else $error("Capture did not copy counter and set flag");
  capture_blocked_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    top_from_capture(wgm) |-> !capture_evt)
    else $error("Capture fired in capture-top mode");
  flag_clear_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (WR && ADDR == ADDR_FLAGS && WDATA[FLAG_CAP_BIT] && !capture_evt) |=> !st_reg.capture_flag)
    else $error("Capture flag not cleared by writing one");
  cap_irq_gate_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CAP_IRQ |-> $past(st_next.capture_flag & st_next.capture_irq_enable))
    else $error("Capture interrupt without enabled flag");
  hold_keeps_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (!WR && !(RD && (ADDR == ADDR_CNT_LO || ADDR == ADDR_CAP_LO))) |=> $stable(st_reg.hold))
    else $error("Holding register changed without access");
  normal_wrap_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (tick && wgm == WGM_NORMAL && st_reg.count_value == CNT_MAX && !WR)
      |=> (st_reg.overflow_flag && st_reg.count_value == CNT_BOTTOM))
    else $error("Normal mode wrap did not set overflow");
endmodule
`default_nettype wire

// file: verification/tcc_core_model.sv
// Processor core model: byte reads and writes on the timer register port
`timescale 1ns/1ps
`default_nettype none
module tcc_core_model (
  input wire logic clk,
  output logic [3:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata
);
  initial begin
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // Data no longer valid once the strobe drops
    wdata <= ~d;
  endtask
  task automatic rd8(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // ----------------------------------------
  // 16-bit transfers through the holding byte
  // ----------------------------------------
  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    wr8(lo + 4'h1, v[15:8]);
    wr8(lo, v[7:0]);
  endtask
  task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
    rd8(lo, v[7:0]);
    rd8(lo + 4'h1, v[15:8]);
  endtask
endmodule
`default_nettype wire

// file: verification/test_tcc_timer.sv
// Self-checking testbench of the 16-bit timer with input capture
`timescale 1ns/1ps
`default_nettype none
module test_tcc_timer;
  import tcc_pkg::*;
  typedef struct packed {logic [3:0] lo; logic [15:0] wv; logic [15:0] ev;} tcc_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr;
  logic rd;
  logic ext_pin = 1'b0;
  logic cap_pin = 1'b0;
  logic cmp_out = 1'b0;
  logic ovf_ack = 1'b0;
  logic cap_ack = 1'b0;
  logic ovf_irq;
  logic cap_irq;
  logic [4:0] tick = 5'h00;
  logic [15:0] count_value;
  logic [15:0] v;
  int error_cnt = 0;
  int compares = 0;
  int d0;
  int d1;
  tcc_row_t rows[5];
  always #4 clk = ~clk;
  tcc_core_model core (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  tcc_timer tcc_timer_i (.REF_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .PRESCALE_TICK(tick), .EXTERNAL_COUNT_PIN(ext_pin),
    .CAPTURE_INPUT_PIN(cap_pin), .COMPARATOR_OUTPUT(cmp_out), .OVF_IRQ_ACK(ovf_ack),
    .CAP_IRQ_ACK(cap_ack), .OVF_IRQ(ovf_irq), .CAP_IRQ(cap_irq), .COUNT_VALUE(count_value));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (error_cnt == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic ticks(input int n, input logic [4:0] mask);
    repeat (n) begin
      @(posedge clk);
      tick <= mask;
      @(posedge clk);
      tick <= 5'h00;
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic wait_cap(output int n);
    n = 0;
    while (cap_irq !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 40) begin
      error_cnt++;
      close_out();
    end
  endtask
  task automatic pulse(input int which);
    @(posedge clk);
    case (which)
      0: ext_pin <= 1'b1;
      1: cap_pin <= 1'b1;
      2: ovf_ack <= 1'b1;
      default: cap_ack <= 1'b1;
    endcase
    @(posedge clk);
    case (which)
      0: ext_pin <= 1'b0;
      1: cap_pin <= 1'b0;
      2: ovf_ack <= 1'b0;
      default: cap_ack <= 1'b0;
    endcase
    repeat (2) @(posedge clk);
    #1;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rows[0] = '{ADDR_CNT_LO, 16'h01FF, 16'h01FF};
    rows[1] = '{ADDR_CNT_LO, 16'hFFFF, 16'hFFFF};
    rows[2] = '{ADDR_CMPA_LO, 16'hA55A, 16'hA55A};
    rows[3] = '{ADDR_CAP_LO, 16'h1234, 16'h0000};
    rows[4] = '{4'hB, 16'h5A5A, 16'h0000};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(count_value, CNT_BOTTOM);
    chk({14'h0000, ovf_irq, cap_irq}, 16'h0000);
    foreach (rows[i]) begin
      core.wr16(rows[i].lo, rows[i].wv);
      core.rd16(rows[i].lo, v);
      chk(v, rows[i].ev);
    end
    core.wr8(ADDR_CNT_HI, 8'h12);
    core.wr8(ADDR_CNT_LO, 8'h34);
    core.wr8(ADDR_CMPA_LO, 8'h56);
    core.rd16(ADDR_CNT_LO, v);
    chk(v, 16'h1234);
    core.rd16(ADDR_CMPA_LO, v);
    chk(v, 16'h1256);
    core.wr16(ADDR_CNT_LO, 16'h0100);
    ticks(3, 5'h1F);
    chk(count_value, 16'h0100);
    for (int cs = 1; cs <= 5; cs++) begin
      core.wr8(ADDR_CTRL_B, 8'(cs));
      ticks(2, ~(5'h01 << (cs - 1)));
      ticks(3, 5'h01 << (cs - 1));
      chk(count_value, 16'h0100 + 16'(3 * cs));
    end
    core.wr8(ADDR_CTRL_B, {5'h00, CS_EXT_RISE});
    repeat (3) pulse(0);
    repeat (3) @(posedge clk);
    chk(count_value, 16'h0112);
    core.wr8(ADDR_CTRL_B, 8'h01);
    core.wr8(ADDR_CNT_HI, 8'h00);
    fork
      core.wr8(ADDR_CNT_LO, 8'h40);
      ticks(1, 5'h01);
    join
    chk(count_value, 16'h0040);
    core.wr8(ADDR_IRQ_EN, 8'h21);
    core.wr16(ADDR_CNT_LO, 16'hFFFE);
    ticks(1, 5'h01);
    chk({ovf_irq, count_value[14:0]}, 16'h7FFF);
    ticks(1, 5'h01);
    chk({ovf_irq, count_value[14:0]}, 16'h8000);
    pulse(2);
    chk({15'h0000, ovf_irq}, 16'h0000);
    core.wr8(ADDR_CTRL_B, 8'h40);
    core.wr16(ADDR_CNT_LO, 16'h1357);
    @(posedge clk);
    cap_pin <= 1'b1;
    wait_cap(d0);
    core.wr8(ADDR_CTRL_B, 8'h80);
    core.wr8(ADDR_FLAGS, 8'h20);
    #1;
    chk({15'h0000, cap_irq}, 16'h0000);
    core.wr16(ADDR_CNT_LO, 16'h2468);
    @(posedge clk);
    cap_pin <= 1'b0;
    wait_cap(d1);
    chk(16'(d1 - d0), 16'h0004);
    core.rd16(ADDR_CAP_LO, v);
    chk(v, 16'h2468);
    core.wr8(ADDR_CTRL_B, 8'hC0);
    core.wr8(ADDR_FLAGS, 8'h20);
    pulse(1);
    repeat (12) @(posedge clk);
    chk({15'h0000, cap_irq}, 16'h0000);
    core.wr8(ADDR_CMP_CS, 8'h04);
    core.wr8(ADDR_FLAGS, 8'h20);
    core.wr8(ADDR_CTRL_B, 8'h40);
    core.wr16(ADDR_CNT_LO, 16'h0ABC);
    @(posedge clk);
    cmp_out <= 1'b1;
    wait_cap(d0);
    core.rd16(ADDR_CAP_LO, v);
    chk(v, 16'h0ABC);
    pulse(3);
    chk({15'h0000, cap_irq}, 16'h0000);
    core.wr8(ADDR_CTRL_A, 8'h00);
    core.wr8(ADDR_CTRL_B, 8'h59);
    core.wr16(ADDR_CAP_LO, 16'h0300);
    core.rd16(ADDR_CAP_LO, v);
    chk(v, 16'h0300);
    core.wr16(ADDR_CNT_LO, 16'h02FE);
    ticks(3, 5'h01);
    chk(count_value, CNT_BOTTOM);
    core.wr8(ADDR_CMP_CS, 8'h00);
    core.wr8(ADDR_FLAGS, 8'h20);
    pulse(1);
    repeat (12) @(posedge clk);
    chk({15'h0000, cap_irq}, 16'h0000);
    close_out();
  end
endmodule
`default_nettype wire
